// ===== pkg/sis_defines.svh
// Offsets, field positions, reset values and cycle counts for the stack and interrupt sequencer.
`ifndef SIS_DEFINES_SVH
`define SIS_DEFINES_SVH

`define SIS_IO_SP_LOW      6'h3D
`define SIS_IO_SP_HIGH     6'h3E
`define SIS_LAST_SRAM      16'h025F
`define SIS_GIE_BIT        7
`define SIS_ENTRY_CYC      3'h4
`define SIS_WAKE_CYC       3'h4
`define SIS_PC_W           12
`define SIS_IRQ_N          8
`define SIS_IRQ_FLAG_MASK  8'hFE

`endif

// ===== pkg/sis_pkg.sv
// Types shared by the stack and interrupt sequencer modules.
package sis_pkg;

  typedef enum logic [3:0] {
    OP_NONE   = 4'h0,
    OP_PUSH   = 4'h1,
    OP_POP    = 4'h2,
    OP_CALL   = 4'h3,
    OP_RET    = 4'h4,
    OP_ISR_EXIT_INSTR   = 4'h5,
    OP_CLI    = 4'h6,
    OP_SEI    = 4'h7,
    OP_GIE_WR = 4'h8
  } sis_op_t;

  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_CALL  = 9'h002,
    ST_POP1  = 9'h004,
    ST_POP2  = 9'h008,
    ST_RET1  = 9'h010,
    ST_RET2  = 9'h020,
    ST_RET3  = 9'h040,
    ST_WAKE  = 9'h080,
    ST_ENTRY = 9'h100
  } sis_state_t;

  typedef struct packed {
    logic       we;
    logic       re;
    logic [5:0] addr;
    logic [7:0] wdata;
  } sis_io_req_t;

  typedef struct packed {
    logic        we;
    logic        re;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } sis_sram_req_t;

endpackage : sis_pkg

// ===== core/sis_irq_flags.sv
// Interrupt flags, pending detection and fixed-priority selection.
`timescale 1ns/1ps
`include "sis_defines.svh"
module sis_irq_flags
  import sis_pkg::*;
#(
  parameter int unsigned      IRQ_N     = `SIS_IRQ_N,
  parameter logic [IRQ_N-1:0] FLAG_MASK = `SIS_IRQ_FLAG_MASK,
  parameter int unsigned      IDX_W     = $clog2(IRQ_N)
) (
  input  wire logic             core_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [IRQ_N-1:0] cond_in,
  input  wire logic [IRQ_N-1:0] en_in,
  input  wire logic [IRQ_N-1:0] clr_w1_in,
  input  wire logic             ack_in,
  input  wire logic [IDX_W-1:0] ack_idx_in,
  output logic [IRQ_N-1:0]      flags_out,
  output logic                  req_out,
  output logic [IDX_W-1:0]      req_idx_out
);

  logic [IRQ_N-1:0] flag_q;
  logic [IRQ_N-1:0] set_v;
  logic [IRQ_N-1:0] clr_v;
  logic [IRQ_N-1:0] pend_v;

  function automatic logic [IDX_W-1:0] lowest_set(input logic [IRQ_N-1:0] v);
    logic [IDX_W-1:0] idx;
    idx = '0;
    for (int i = IRQ_N - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = IDX_W'(i);
      end
    end
    return idx;
  endfunction : lowest_set

  always_comb begin
    set_v = cond_in & FLAG_MASK;
    clr_v = clr_w1_in & FLAG_MASK;
    if (ack_in) begin
      clr_v[ack_idx_in] = clr_v[ack_idx_in] | FLAG_MASK[ack_idx_in];
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flag_q <= '0;
    end else begin
      flag_q <= set_v | (flag_q & ~clr_v);
    end
  end

  assign pend_v = en_in & ((flag_q & FLAG_MASK) | (cond_in & ~FLAG_MASK));

  assign req_idx_out = lowest_set(pend_v);
  assign req_out     = |pend_v;
  assign flags_out   = flag_q;

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_flag_hold: assert property (##1 ((($past(flag_q) & ~$past(clr_v)) & ~flag_q) == '0))
    else $error("Interrupt flag dropped without a clear.");

  a_flag_clear: assert property (##1 ((flag_q & $past(clr_v) & ~$past(set_v)) == '0))
    else $error("Interrupt flag survived its clear.");

endmodule : sis_irq_flags

// ===== core/sis_stack_irq_seq.sv
// Stack pointer, stack sequencing and interrupt entry and return for the core.
// Summary of operation
// - Push writes the byte at the stack pointer, then lowers it by one.
// - Calls and interrupt entry push the return address, lowering the pointer by two.
// - Pop raises the stack pointer by one and returns the byte there.
// - Returns pop the return address and raise the stack pointer by two.
// - After reset the stack pointer holds the last SRAM address.
// - Stack pointer high byte at I/O 0x3E, low byte at I/O 0x3D.
// - A source is taken only with its enable and the global enable set.
// - Lowest vector address wins; reset first, then external request zero.
// - Taking an interrupt clears the global enable; software may set it again.
// - The interrupt-return instruction sets the global enable again.
// - Vectoring clears the source flag; writing one also clears it.
// - A flagged condition seen while disabled is held until serviced or cleared.
// - Level sources without flags request only while the condition stands.
// - After interrupt return one instruction runs before another interrupt.
// - The global-disable instruction masks interrupts at once, same cycle included.
// - After the global-enable instruction the next instruction runs first.
// - Entry and return never save or restore the core flags register.
// - Entry takes four cycles, pushing the program counter, before the vector.
// - Interrupts wait for a multi-cycle instruction to complete.
// - Waking from sleep adds four cycles to the entry latency.
// - Interrupt return takes four cycles: pop two bytes, raise pointer, set enable.
// - The program counter is 10, 11 or 12 bits wide.
// - The global enable is bit 7 of the core flags register.
`timescale 1ns/1ps
`include "sis_defines.svh"
module sis_stack_irq_seq
  import sis_pkg::*;
#(
  parameter int unsigned      PC_W      = `SIS_PC_W,
  parameter int unsigned      IRQ_N     = `SIS_IRQ_N,
  parameter logic [IRQ_N-1:0] FLAG_MASK = `SIS_IRQ_FLAG_MASK,
  parameter logic [15:0]      LAST_SRAM = `SIS_LAST_SRAM
) (
  input  wire logic             core_clk_in,
  input  wire logic             rstn_in,
  input  wire sis_op_t          op_in,
  input  wire logic [PC_W-1:0]  op_pc_in,
  input  wire logic [7:0]       op_data_in,
  input  wire logic             boundary_in,
  input  wire logic             sleep_in,
  input  wire sis_io_req_t      io_in,
  output logic [7:0]            io_rdata_out,
  output sis_sram_req_t         sram_out,
  input  wire logic [7:0]       sram_rdata_in,
  input  wire logic [IRQ_N-1:0] irq_cond_in,
  input  wire logic [IRQ_N-1:0] irq_en_in,
  input  wire logic [IRQ_N-1:0] irq_clr_w1_in,
  output logic [IRQ_N-1:0]      irq_flags_out,
  output logic                  gie_out,
  output logic                  busy_out,
  output logic                  done_out,
  output logic [7:0]            pop_data_out,
  output logic [PC_W-1:0]       ret_pc_out,
  output logic                  vec_valid_out,
  output logic [PC_W-1:0]       vec_pc_out
);

  localparam int unsigned IDX_W = $clog2(IRQ_N);

  logic             rst_sync1_q;
  logic             rst_n_q;
  sis_state_t       st_q;
  logic [15:0]      sp_q;
  sis_sram_req_t    sram_q;
  logic [15:0]      pc_hold_q;
  logic [7:0]       ret_hi_q;
  logic             is_isr_exit_instr_q;
  logic [2:0]       cnt_q;
  logic             gie_q;
  logic             hold_q;
  logic             done_q;
  logic [7:0]       pop_q;
  logic [PC_W-1:0]  ret_pc_q;
  logic             vec_valid_q;
  logic [PC_W-1:0]  vec_pc_q;
  logic [7:0]       io_rdata_q;
  logic             idle;
  logic             take;
  logic             irq_req;
  logic [IDX_W-1:0] irq_idx;

  function automatic sis_sram_req_t wr_req(input logic [15:0] a, input logic [7:0] d);
    sis_sram_req_t r;
    r       = '0;
    r.we    = 1'b1;
    r.addr  = a;
    r.wdata = d;
    return r;
  endfunction : wr_req

  function automatic sis_sram_req_t rd_req(input logic [15:0] a);
    sis_sram_req_t r;
    r      = '0;
    r.re   = 1'b1;
    r.addr = a;
    return r;
  endfunction : rd_req

  function automatic logic [PC_W-1:0] vector_of(input logic [IDX_W-1:0] idx);
    return PC_W'(idx) + PC_W'(1);
  endfunction : vector_of

  // Reset is released through two flip-flops.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_sync1_q <= 1'b0;
      rst_n_q     <= 1'b0;
    end else begin
      rst_sync1_q <= 1'b1;
      rst_n_q     <= rst_sync1_q;
    end
  end

  sis_irq_flags #(
    .IRQ_N     (IRQ_N),
    .FLAG_MASK (FLAG_MASK),
    .IDX_W     (IDX_W)
  ) u_flags (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_q),
    .cond_in     (irq_cond_in),
    .en_in       (irq_en_in),
    .clr_w1_in   (irq_clr_w1_in),
    .ack_in      (take),
    .ack_idx_in  (irq_idx),
    .flags_out   (irq_flags_out),
    .req_out     (irq_req),
    .req_idx_out (irq_idx)
  );

  assign idle = (st_q == ST_IDLE);

  // Any op, disable included, blocks it.
  // Boundary sees settled enables and flags.
  assign take = idle && (op_in == OP_NONE) && boundary_in && gie_q && !hold_q && irq_req;

  // Stack pointer, memory requests and sequencing.
  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q        <= ST_IDLE;
      sp_q        <= LAST_SRAM;
      sram_q      <= '0;
      pc_hold_q   <= 16'h0000;
      ret_hi_q    <= 8'h00;
      is_isr_exit_instr_q   <= 1'b0;
      cnt_q       <= 3'h0;
      done_q      <= 1'b0;
      pop_q       <= 8'h00;
      ret_pc_q    <= '0;
      vec_valid_q <= 1'b0;
      vec_pc_q    <= '0;
    end else begin
      sram_q      <= '0;
      done_q      <= 1'b0;
      vec_valid_q <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (take) begin
            pc_hold_q <= 16'(op_pc_in);
            vec_pc_q  <= vector_of(irq_idx);
            if (sleep_in) begin
              st_q  <= ST_WAKE;
              cnt_q <= 3'h0;
            end else begin
              sram_q <= wr_req(sp_q, 8'(op_pc_in));
              sp_q   <= sp_q - 16'h0001;
              st_q   <= ST_ENTRY;
              cnt_q  <= 3'h1;
            end
          end else begin
            case (op_in)
              OP_PUSH: begin
                sram_q <= wr_req(sp_q, op_data_in);
                sp_q   <= sp_q - 16'h0001;
                done_q <= 1'b1;
              end
              OP_CALL: begin
                sram_q    <= wr_req(sp_q, 8'(op_pc_in));
                sp_q      <= sp_q - 16'h0001;
                pc_hold_q <= 16'(op_pc_in);
                st_q      <= ST_CALL;
              end
              OP_POP: begin
                sram_q <= rd_req(sp_q + 16'h0001);
                sp_q   <= sp_q + 16'h0001;
                st_q   <= ST_POP1;
              end
              OP_RET, OP_ISR_EXIT_INSTR: begin
                sram_q    <= rd_req(sp_q + 16'h0001);
                sp_q      <= sp_q + 16'h0001;
                is_isr_exit_instr_q <= (op_in == OP_ISR_EXIT_INSTR);
                st_q      <= ST_RET1;
              end
              default: begin
                st_q <= ST_IDLE;
              end
            endcase
          end
        end
        ST_CALL: begin
          sram_q <= wr_req(sp_q, pc_hold_q[15:8]);
          sp_q   <= sp_q - 16'h0001;
          done_q <= 1'b1;
          st_q   <= ST_IDLE;
        end
        ST_POP1: begin
          st_q <= ST_POP2;
        end
        ST_POP2: begin
          pop_q  <= sram_rdata_in;
          done_q <= 1'b1;
          st_q   <= ST_IDLE;
        end
        ST_RET1: begin
          sram_q <= rd_req(sp_q + 16'h0001);
          sp_q   <= sp_q + 16'h0001;
          st_q   <= ST_RET2;
        end
        ST_RET2: begin
          ret_hi_q <= sram_rdata_in;
          st_q     <= ST_RET3;
        end
        ST_RET3: begin
          ret_pc_q <= PC_W'({ret_hi_q, sram_rdata_in});
          done_q   <= 1'b1;
          st_q     <= ST_IDLE;
        end
        ST_WAKE: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == `SIS_WAKE_CYC - 3'h1) begin
            sram_q <= wr_req(sp_q, pc_hold_q[7:0]);
            sp_q   <= sp_q - 16'h0001;
            st_q   <= ST_ENTRY;
            cnt_q  <= 3'h1;
          end
        end
        ST_ENTRY: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == 3'h1) begin
            sram_q <= wr_req(sp_q, pc_hold_q[15:8]);
            sp_q   <= sp_q - 16'h0001;
          end
          if (cnt_q == `SIS_ENTRY_CYC - 3'h1) begin
            vec_valid_q <= 1'b1;
            st_q        <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
      if (io_in.we && io_in.addr == `SIS_IO_SP_LOW) begin
        sp_q[7:0] <= io_in.wdata;
      end
      if (io_in.we && io_in.addr == `SIS_IO_SP_HIGH) begin
        sp_q[15:8] <= io_in.wdata;
      end
    end
  end

  // Global enable; the other flags are left to software.
  // Only the enable bit is touched.
  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      gie_q <= 1'b0;
    end else if (take) begin
      gie_q <= 1'b0;
    end else if (st_q == ST_RET3 && is_isr_exit_instr_q) begin
      gie_q <= 1'b1;
    end else if (idle) begin
      case (op_in)
        OP_CLI:    gie_q <= 1'b0;
        OP_SEI:    gie_q <= 1'b1;
        // Bit 7 of the flags byte.
        OP_GIE_WR: gie_q <= op_data_in[`SIS_GIE_BIT];
        default:   gie_q <= gie_q;
      endcase
    end
  end

  // One boundary is skipped after OP_SEI or an interrupt return.
  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      hold_q <= 1'b0;
    end else if (st_q == ST_RET3 && is_isr_exit_instr_q) begin
      hold_q <= 1'b1;
    end else if (idle && op_in == OP_SEI) begin
      hold_q <= 1'b1;
    end else if (idle && op_in == OP_NONE && boundary_in) begin
      hold_q <= 1'b0;
    end
  end

  // I/O reads of the pointer bytes.
  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      io_rdata_q <= 8'h00;
    end else if (io_in.re) begin
      case (io_in.addr)
        `SIS_IO_SP_LOW:  io_rdata_q <= sp_q[7:0];
        `SIS_IO_SP_HIGH: io_rdata_q <= sp_q[15:8];
        default:         io_rdata_q <= 8'h00;
      endcase
    end
  end

  assign io_rdata_out  = io_rdata_q;
  assign sram_out      = sram_q;
  assign gie_out       = gie_q;
  assign busy_out      = !idle;
  assign done_out      = done_q;
  assign pop_data_out  = pop_q;
  assign ret_pc_out    = ret_pc_q;
  assign vec_valid_out = vec_valid_q;
  assign vec_pc_out    = vec_pc_q;

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_q);

  sequence s_call_go;
    idle && op_in == OP_CALL && !io_in.we ##1 !io_in.we;
  endsequence

  sequence s_ret_go;
    idle && (op_in == OP_RET || op_in == OP_ISR_EXIT_INSTR) && !io_in.we ##1 !io_in.we;
  endsequence

  a_sp_reset: assert property ($rose(rst_n_q) |-> sp_q == LAST_SRAM)
    else $error("Stack pointer not at SRAM top after reset.");

  a_push_dec: assert property (idle && op_in == OP_PUSH && !io_in.we
      |=> sp_q == $past(sp_q) - 16'h0001 && sram_out.we)
    else $error("Push did not lower the pointer by one.");

  a_call_dec: assert property (s_call_go |=> sp_q == $past(sp_q, 2) - 16'h0002)
    else $error("Call did not lower the pointer by two.");

  a_pop_inc: assert property (idle && op_in == OP_POP && !io_in.we
      |=> sp_q == $past(sp_q) + 16'h0001 ##1 !done_q ##1 done_q)
    else $error("Pop did not raise the pointer by one in time.");

  a_ret_inc: assert property (s_ret_go |=> sp_q == $past(sp_q, 2) + 16'h0002)
    else $error("Return did not raise the pointer by two.");

  a_sp_read: assert property (io_in.re && io_in.addr == `SIS_IO_SP_HIGH
      |=> io_rdata_out == $past(sp_q[15:8]))
    else $error("High pointer byte read wrong.");

  a_take_gate: assert property (take |-> gie_q && irq_en_in[irq_idx])
    else $error("Interrupt taken while disabled.");

  a_take_clr: assert property (take |=> !gie_q && busy_out)
    else $error("Entry left the global enable set.");

  a_isr_exit_instr_gie: assert property (idle && op_in == OP_ISR_EXIT_INSTR
      |=> !done_q [*3] ##1 (gie_q && hold_q && done_q))
    else $error("Interrupt return did not set the enable on time.");

  a_cli_mask: assert property (idle && op_in == OP_CLI |-> !take ##1 !gie_q)
    else $error("Interrupt taken across the disable instruction.");

  a_entry_time: assert property (take && !sleep_in
      |=> !vec_valid_q [*3] ##1 vec_valid_q)
    else $error("Entry latency not four cycles.");

  a_wake_time: assert property (take && sleep_in
      |=> !vec_valid_q [*7] ##1 vec_valid_q)
    else $error("Wake entry latency not eight cycles.");

endmodule : sis_stack_irq_seq

// ===== tb/sis_sram_model.sv
// Behavioural data SRAM that answers the stack requests of the sequencer.
`timescale 1ns/1ps
module sis_sram_model
  import sis_pkg::*;
(
  input  wire logic          clk_in,
  input  wire sis_sram_req_t req_in,
  output logic [7:0]         rdata_out
);
  logic [7:0] mem [0:65535];
  logic [7:0] rdata_q = 8'h5A;

  // Read data follows a read by one cycle; between reads the bus toggles.
  always @(posedge clk_in) begin
    if (req_in.we) begin
      mem[req_in.addr] <= req_in.wdata;
    end
    if (req_in.re) begin
      rdata_q <= mem[req_in.addr];
    end else begin
      rdata_q <= ~rdata_q;
    end
  end

  assign rdata_out = rdata_q;
endmodule : sis_sram_model

// ===== tb/sis_stack_irq_seq_bench.sv
// Self-checking bench for the stack and interrupt sequencer.
`timescale 1ns/1ps
`include "sis_defines.svh"
module sis_stack_irq_seq_bench;
  import sis_pkg::*;
  logic          core_clk    = 1'b0;
  logic          rstn        = 1'b0;
  sis_op_t       op          = OP_NONE;
  logic [11:0]   op_pc       = 12'h000;
  logic [7:0]    op_data     = 8'h00;
  logic          bnd         = 1'b0;
  logic          sleep       = 1'b0;
  sis_io_req_t   io          = '0;
  logic [7:0]    cond        = 8'h00;
  logic [7:0]    en          = 8'h00;
  logic [7:0]    clr         = 8'h00;
  logic [7:0]    io_rdata;
  sis_sram_req_t sram_req;
  logic [7:0]    sram_rdata;
  logic [7:0]    flags;
  logic          gie;
  logic          busy;
  logic          done;
  logic          vec_valid;
  logic [7:0]    pop_data;
  logic [11:0]   ret_pc;
  logic [11:0]   vec_pc;
  logic [7:0]    rd;
  int            cnt;
  int            n_errors    = 0;
  int            check_count = 0;

  always #4 core_clk = ~core_clk;

  sis_stack_irq_seq sis_stack_irq_seq_inst (
    .core_clk_in   (core_clk),
    .rstn_in       (rstn),
    .op_in         (op),
    .op_pc_in      (op_pc),
    .op_data_in    (op_data),
    .boundary_in   (bnd),
    .sleep_in      (sleep),
    .io_in         (io),
    .io_rdata_out  (io_rdata),
    .sram_out      (sram_req),
    .sram_rdata_in (sram_rdata),
    .irq_cond_in   (cond),
    .irq_en_in     (en),
    .irq_clr_w1_in (clr),
    .irq_flags_out (flags),
    .gie_out       (gie),
    .busy_out      (busy),
    .done_out      (done),
    .pop_data_out  (pop_data),
    .ret_pc_out    (ret_pc),
    .vec_valid_out (vec_valid),
    .vec_pc_out    (vec_pc)
  );

  sis_sram_model sis_sram_model_inst (
    .clk_in    (core_clk),
    .req_in    (sram_req),
    .rdata_out (sram_rdata)
  );

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick;
    @(negedge core_clk);
  endtask : tick

  task automatic io_acc(input logic wr, input logic [5:0] a, input logic [7:0] d);
    tick;
    io = '{we: wr, re: !wr, addr: a, wdata: d};
    tick;
    io = '0;
    rd = io_rdata;
  endtask : io_acc

  task automatic sp_chk(input logic [15:0] exp);
    logic [7:0] hi;
    io_acc(1'b0, `SIS_IO_SP_HIGH, 8'h00);
    hi = rd;
    io_acc(1'b0, `SIS_IO_SP_LOW, 8'h00);
    chk({hi, rd}, exp);
  endtask : sp_chk

  task automatic do_op(input sis_op_t o, input logic [11:0] pc, input logic [7:0] d,
                       input bit w);
    tick;
    op = o;
    op_pc = pc;
    op_data = d;
    tick;
    op = OP_NONE;
    cnt = 1;
    while (w && done !== 1'b1 && cnt < 10) begin
      tick;
      cnt++;
    end
    if (w && done !== 1'b1) begin
      n_errors++;
      end_of_test;
    end
  endtask : do_op

  task automatic take(input logic [11:0] pc);
    tick;
    bnd = 1'b1;
    op_pc = pc;
    tick;
    bnd = 1'b0;
    cnt = 1;
    while (vec_valid !== 1'b1 && cnt < 12) begin
      tick;
      cnt++;
    end
    if (vec_valid !== 1'b1) begin
      cnt = 0;
    end
  endtask : take

  task automatic pulse_cond(input logic [7:0] c);
    tick;
    cond = c;
    tick;
    cond = 8'h00;
    tick;
    tick;
  endtask : pulse_cond

  function automatic logic [15:0] mem_pair(input logic [15:0] a);
    return {sis_sram_model_inst.mem[a - 16'h0001], sis_sram_model_inst.mem[a]};
  endfunction : mem_pair

  initial begin
    repeat (8) tick;
    rstn = 1'b1;
    repeat (3) tick;
    sp_chk(`SIS_LAST_SRAM);
    chk(16'(gie), 16'h0000);
    io_acc(1'b1, `SIS_IO_SP_HIGH, 8'h01);
    io_acc(1'b1, `SIS_IO_SP_LOW, 8'h00);
    sp_chk(16'h0100);
    io_acc(1'b0, 6'h20, 8'h00);
    chk(16'(rd), 16'h0000);
    do_op(OP_PUSH, 12'h000, 8'hA5, 1'b1);
    sp_chk(16'h00FF);
    chk(16'(sis_sram_model_inst.mem[16'h0100]), 16'h00A5);
    do_op(OP_POP, 12'h000, 8'h00, 1'b1);
    chk(16'(pop_data), 16'h00A5);
    sp_chk(16'h0100);
    do_op(OP_CALL, 12'hABC, 8'h00, 1'b1);
    sp_chk(16'h00FE);
    chk(mem_pair(16'h0100), 16'h0ABC);
    do_op(OP_RET, 12'h000, 8'h00, 1'b1);
    chk(16'(ret_pc), 16'h0ABC);
    sp_chk(16'h0100);
    pulse_cond(8'h01);
    chk(16'(flags), 16'h0000);
    pulse_cond(8'h24);
    chk(16'(flags), 16'h0024);
    tick;
    clr = 8'h20;
    tick;
    clr = 8'h00;
    tick;
    chk(16'(flags), 16'h0004);
    pulse_cond(8'h20);
    en = 8'hFF;
    take(12'h010);
    chk(16'(cnt), 16'h0000);
    do_op(OP_SEI, 12'h000, 8'h00, 1'b0);
    take(12'h010);
    chk(16'(cnt), 16'h0000);
    en = 8'h00;
    take(12'h010);
    chk(16'(cnt), 16'h0000);
    do_op(OP_CLI, 12'h000, 8'h00, 1'b0);
    en = 8'hFF;
    take(12'h010);
    chk(16'(cnt), 16'h0000);
    do_op(OP_GIE_WR, 12'h000, 8'h80, 1'b0);
    chk(16'(gie), 16'h0001);
    take(12'h123);
    chk(16'(cnt), 16'h0004);
    chk(16'(vec_pc), 16'h0003);
    chk(16'(gie), 16'h0000);
    chk(16'(flags), 16'h0020);
    sp_chk(16'h00FE);
    chk(mem_pair(16'h0100), 16'h0123);
    do_op(OP_ISR_EXIT_INSTR, 12'h000, 8'h00, 1'b1);
    chk(16'(cnt), 16'h0004);
    chk(16'(ret_pc), 16'h0123);
    chk(16'(gie), 16'h0001);
    sp_chk(16'h0100);
    take(12'h200);
    chk(16'(cnt), 16'h0000);
    sleep = 1'b1;
    take(12'h200);
    chk(16'(cnt), 16'h0008);
    chk(16'(vec_pc), 16'h0006);
    sleep = 1'b0;
    chk(16'(busy), 16'h0000);
    do_op(OP_GIE_WR, 12'h000, 8'h80, 1'b0);
    cond = 8'h21;
    tick;
    op = OP_CALL;
    op_pc = 12'h345;
    tick;
    op = OP_NONE;
    bnd = 1'b1;
    tick;
    bnd = 1'b0;
    chk(16'(done), 16'h0001);
    repeat (4) tick;
    chk(16'(gie), 16'h0001);
    take(12'h345);
    chk(16'(cnt), 16'h0004);
    chk(16'(vec_pc), 16'h0001);
    cond = 8'h00;
    chk(16'(flags), 16'h0020);
    sp_chk(16'h00FA);
    end_of_test;
  end
endmodule : sis_stack_irq_seq_bench
